// [core/rxcfg_regs.sv]
/*
 Receiver and host serial speed configuration bank: five configuration
 registers, a status register, the receive guard blanking timer, level
 and collision comparators, and the serial bit-rate generator.
 Assumes a 50 MHz clock, synchronous inputs, a 27.12 MHz crystal tick
 and a half-bit tick from the receive timing logic outside.
*/
`timescale 1ns/1ps
`include "rxcfg_consts.svh"

module rxcfg_regs (
    input  wire logic                     ref_clk,
    input  wire logic                     reset,
    input  wire rxcfg_pkg::rxcfg_bus_t    bus,
    output logic [7:0]                    rdata,
    input  wire logic                     tx_end,
    input  wire logic                     half_bit_tick,
    input  wire logic                     rx_in,
    input  wire logic [3:0]               signal_level,
    input  wire logic [3:0]               phase_level,
    input  wire logic [7:0]               main_strength,
    input  wire logic [7:0]               sec_strength,
    input  wire logic                     xtal_tick,
    input  wire logic                     char_start,
    output rxcfg_pkg::rxcfg_rx_ctrl_t     rx_ctrl,
    output logic                          rx_blank,
    output logic                          rx_in_gated,
    output logic                          decoder_level_ok,
    output logic                          phase_level_ok,
    output logic                          collision,
    output logic [12:0]                   baud_divisor,
    output logic                          baud_tick,
    output logic                          char_active,
    output logic [3:0]                    char_bit_index,
    output logic                          char_done
);
    import rxcfg_pkg::*;

    localparam logic [5:0] CARR16_LAST = 6'(`RXCFG_CARR16_CYC - 1);

    rxcfg_state_t s_q;
    rxcfg_state_t s_d;
    logic [12:0]  divisor;
    logic [10:0]  sec_scaled;
    logic [2:0]   bexp;
    logic [12:0]  mant13;

    // ==========================================================
    // Bit-rate divisor in crystal periods
    always_comb
    begin
        bexp   = s_q.baud_reg[`RXCFG_BAUD_EXP];
        mant13 = {8'h00, s_q.baud_reg[`RXCFG_BAUD_MANT]};
        if (bexp == 3'h0)
            divisor = mant13 + 13'h0001;
        else
            divisor = (mant13 + `RXCFG_MANT_OFS) << (bexp - 3'h1);
    end

    // ==========================================================
    // Next-state logic
    always_comb
    begin
        s_d           = s_q;
        s_d.rdata     = 8'h00;
        s_d.baud_tick = 1'b0;
        s_d.char_done = 1'b0;
        sec_scaled    = 11'h000;

        // Register writes; bits with no storage read back as zero
        if (bus.wr)
        begin
            if (bus.addr == `RXCFG_OFF_GUARD)
                s_d.guard_reg = bus.wdata;
            else if (bus.addr == `RXCFG_OFF_THRESH)
                s_d.thresh_reg = bus.wdata;
            else if (bus.addr == `RXCFG_OFF_INPUT)
                s_d.input_reg = bus.wdata & `RXCFG_INPUT_MASK;
            else if (bus.addr == `RXCFG_OFF_ANALOG)
                s_d.analog_reg = bus.wdata & `RXCFG_ANALOG_MASK;
            else if (bus.addr == `RXCFG_OFF_BAUD)
                s_d.baud_reg = bus.wdata;
        end

        // Register reads, answered in the following cycle
        if (bus.rd)
        begin
            if (bus.addr == `RXCFG_OFF_GUARD)
                s_d.rdata = s_q.guard_reg;
            else if (bus.addr == `RXCFG_OFF_THRESH)
                s_d.rdata = s_q.thresh_reg;
            else if (bus.addr == `RXCFG_OFF_INPUT)
                s_d.rdata = s_q.input_reg;
            else if (bus.addr == `RXCFG_OFF_ANALOG)
                s_d.rdata = s_q.analog_reg;
            else if (bus.addr == `RXCFG_OFF_STATUS)
                s_d.rdata = {3'h0, s_q.fstate == FR_BITS, s_q.dec_ok,
                             s_q.ph_ok, s_q.collision,
                             s_q.guard_left != 7'h00};
            else if (bus.addr == `RXCFG_OFF_BAUD)
                s_d.rdata = s_q.baud_reg;
        end

        // ======================================================
        // Guard blanking timer
        if (tx_end)
        begin
            s_d.guard_left = s_q.guard_reg[`RXCFG_GUARD_CNT];
            s_d.unit_cnt   = 6'h00;
        end
        else if (s_q.guard_left != 7'h00)
        begin
            if (!s_q.guard_reg[`RXCFG_GUARD_UNIT])
            begin
                if (s_q.unit_cnt == CARR16_LAST)
                begin
                    s_d.unit_cnt   = 6'h00;
                    s_d.guard_left = s_q.guard_left - 7'h01;
                end
                else
                    s_d.unit_cnt = s_q.unit_cnt + 6'h01;
            end
            else if (half_bit_tick)
                s_d.guard_left = s_q.guard_left - 7'h01;
        end
        // Input is dropped while blanked
        s_d.rx_gated = rx_in & (s_q.guard_left == 7'h00);

        // ======================================================
        // Level and collision comparators
        s_d.dec_ok = signal_level >= s_q.thresh_reg[`RXCFG_DEC_MIN];
        s_d.ph_ok  = phase_level >= s_q.thresh_reg[`RXCFG_PH_MIN];
        case (s_q.input_reg[`RXCFG_COLL_LVL])
            2'h0: sec_scaled = {3'h0, sec_strength} << 3;
            2'h1: sec_scaled = {3'h0, sec_strength} << 2;
            2'h2: sec_scaled = {3'h0, sec_strength} << 1;
            default: sec_scaled = 11'h000;
        endcase
        s_d.collision = (s_q.input_reg[`RXCFG_COLL_LVL] != `RXCFG_COLL_OFF)
                        && (sec_scaled >= {3'h0, main_strength})
                        && (main_strength != 8'h00);

        // ======================================================
        // Bit-rate generator; a new setting restarts the period
        if (bus.wr && bus.addr == `RXCFG_OFF_BAUD)
            s_d.div_cnt = 13'h0000;
        else if (xtal_tick)
        begin
            if (s_q.div_cnt >= divisor - 13'h0001)
            begin
                s_d.div_cnt   = 13'h0000;
                s_d.baud_tick = 1'b1;
            end
            else
                s_d.div_cnt = s_q.div_cnt + 13'h0001;
        end

        // ======================================================
        // Character framing: start, eight data, stop, no parity
        case (s_q.fstate)
            FR_IDLE:
            begin
                if (char_start)
                begin
                    s_d.fstate  = FR_BITS;
                    s_d.bit_idx = 4'h0;
                end
            end
            FR_BITS:
            begin
                if (s_q.baud_tick)
                begin
                    if (s_q.bit_idx == `RXCFG_FRAME_BITS - 4'h1)
                    begin
                        s_d.fstate    = FR_IDLE;
                        s_d.bit_idx   = 4'h0;
                        s_d.char_done = 1'b1;
                    end
                    else
                        s_d.bit_idx = s_q.bit_idx + 4'h1;
                end
            end
            default: s_d.fstate = FR_IDLE;
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            s_q            <= '0;
            s_q.guard_reg  <= `RXCFG_GUARD_RST;
            s_q.thresh_reg <= `RXCFG_THRESH_RST;
            s_q.input_reg  <= `RXCFG_INPUT_RST;
            s_q.analog_reg <= `RXCFG_ANALOG_RST;
            s_q.baud_reg   <= `RXCFG_BAUD_RST;
        end
        else
            s_q <= s_d;
    end

    // ==========================================================
    // Outputs
    assign rdata            = s_q.rdata;
    assign rx_ctrl.quasi_diff = s_q.input_reg[`RXCFG_QUASI_DIFF];
    assign rx_ctrl.converter_mode_select =
        s_q.input_reg[`RXCFG_CONV_MODE];
    assign rx_ctrl.signal_source_select =
        s_q.input_reg[`RXCFG_SIG_SRC];
    assign rx_ctrl.collision_strength_level =
        s_q.input_reg[`RXCFG_COLL_LVL];
    assign rx_ctrl.hpcf     = s_q.analog_reg[`RXCFG_HPCF];
    assign rx_ctrl.gain     = s_q.analog_reg[`RXCFG_GAIN];
    assign rx_blank         = s_q.guard_left != 7'h00;
    assign rx_in_gated      = s_q.rx_gated;
    assign decoder_level_ok = s_q.dec_ok;
    assign phase_level_ok   = s_q.ph_ok;
    assign collision        = s_q.collision;
    assign baud_divisor     = divisor;
    assign baud_tick        = s_q.baud_tick;
    assign char_active      = s_q.fstate == FR_BITS;
    assign char_bit_index   = s_q.bit_idx;
    assign char_done        = s_q.char_done;

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_unit_done;
        rx_blank && !tx_end && !s_q.guard_reg[`RXCFG_GUARD_UNIT]
            && s_q.unit_cnt == CARR16_LAST;
    endsequence

    a_guard_load: assert property (tx_end |=>
        s_q.guard_left == $past(s_q.guard_reg[6:0]))
        else $error("guard count not loaded at transmit end");
    a_guard_carrier: assert property (s_unit_done |=>
        s_q.guard_left == $past(s_q.guard_left) - 7'h01)
        else $error("carrier unit step wrong");
    a_guard_halfbit: assert property (rx_blank && !tx_end
        && s_q.guard_reg[7] && half_bit_tick |=>
        s_q.guard_left == $past(s_q.guard_left) - 7'h01)
        else $error("half bit unit step wrong");
    a_blank_gates: assert property (rx_blank |=> !rx_in_gated)
        else $error("input passed while blanked");
    // Comparators hold zero through reset, so the first edge is skipped
    a_dec_level: assert property (!$past(reset) |->
        decoder_level_ok ==
        ($past(signal_level) >= $past(s_q.thresh_reg[7:4])))
        else $error("decoder level compare wrong");
    a_phase_level: assert property (!$past(reset) |->
        phase_level_ok ==
        ($past(phase_level) >= $past(s_q.thresh_reg[3:0])))
        else $error("phase level compare wrong");
    a_coll_off: assert property
        (s_q.input_reg[1:0] == 2'h3 |=> !collision)
        else $error("collision flagged while disabled");
    a_coll_eighth: assert property (s_q.input_reg[1:0] == 2'h0
        && main_strength == 8'h40 && sec_strength == 8'h08 |=> collision)
        else $error("one eighth collision missed");
    a_baud_div: assert property ((bexp == 3'h0) |->
        divisor == {8'h00, s_q.baud_reg[4:0]} + 13'h0001)
        else $error("divisor wrong at exponent zero");
    a_baud_reset: assert property ($rose(!reset) |->
        s_q.baud_reg == 8'h7A && divisor == 13'h00EC)
        else $error("baud reset value wrong");
    a_frame_end: assert property (char_active && baud_tick
        && char_bit_index == 4'h9 |=> char_done && !char_active)
        else $error("character frame length wrong");
    a_guard_zero: assert property (tx_end
        && s_q.guard_reg[6:0] == 7'h00 |=> !rx_blank)
        else $error("zero guard count blanked the input");
    a_baud_restart: assert property (bus.wr
        && bus.addr == `RXCFG_OFF_BAUD |=> s_q.div_cnt == 13'h0000
        && !baud_tick)
        else $error("bit period not restarted by baud write");
    a_frame_start: assert property (!char_active && char_start
        |=> char_active && char_bit_index == 4'h0)
        else $error("character frame did not start");

endmodule

// [inc/rxcfg_consts.svh]
/*
 Constants of the receiver and serial speed configuration bank: register
 offsets, field positions, reset values and timing counts.
 Assumes a 50 MHz system clock and a byte-wide register port.
*/
`ifndef RXCFG_CONSTS_SVH
`define RXCFG_CONSTS_SVH

// ==========================================================
// Register offsets
`define RXCFG_OFF_GUARD    8'h36
`define RXCFG_OFF_THRESH   8'h37
`define RXCFG_OFF_INPUT    8'h38
`define RXCFG_OFF_ANALOG   8'h39
`define RXCFG_OFF_STATUS   8'h3A
`define RXCFG_OFF_BAUD     8'h3B

// ==========================================================
// Reset values
`define RXCFG_GUARD_RST    8'h00
`define RXCFG_THRESH_RST   8'h00
`define RXCFG_INPUT_RST    8'h00
`define RXCFG_ANALOG_RST   8'h00
`define RXCFG_BAUD_RST     8'h7A

// ==========================================================
// Field positions
`define RXCFG_GUARD_UNIT   7
`define RXCFG_GUARD_CNT    6:0
`define RXCFG_DEC_MIN      7:4
`define RXCFG_PH_MIN       3:0
`define RXCFG_QUASI_DIFF   7
`define RXCFG_CONV_MODE    6
`define RXCFG_SIG_SRC      5:4
`define RXCFG_COLL_LVL     1:0
`define RXCFG_TRIM         7:6
`define RXCFG_HPCF         3:2
`define RXCFG_GAIN         1:0
`define RXCFG_BAUD_EXP     7:5
`define RXCFG_BAUD_MANT    4:0
// Writable bits per register; the rest read as zero
`define RXCFG_INPUT_MASK   8'hF3
`define RXCFG_ANALOG_MASK  8'hCF

// ==========================================================
// Timing
`define RXCFG_CLK_PS       20000
// Sixteen carrier periods at 13.56 MHz, in picoseconds
`define RXCFG_CARR16_PS    1179941
`define RXCFG_CARR16_CYC   (`RXCFG_CARR16_PS / `RXCFG_CLK_PS)
`define RXCFG_MANT_OFS     13'h0021
`define RXCFG_DATA_BITS    8
`define RXCFG_FRAME_BITS   4'hA
`define RXCFG_COLL_OFF     2'h3

`endif

// [inc/rxcfg_pkg.sv]
/*
 Types of the receiver and serial speed configuration bank.
 Assumes rxcfg_consts.svh is on the include path.
*/
package rxcfg_pkg;

    typedef enum logic {FR_IDLE, FR_BITS} rxcfg_frame_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } rxcfg_bus_t;

    typedef struct packed {
        logic       quasi_diff;
        logic       converter_mode_select;
        logic [1:0] signal_source_select;
        logic [1:0] collision_strength_level;
        logic [1:0] hpcf;
        logic [1:0] gain;
    } rxcfg_rx_ctrl_t;

    typedef struct packed {
        logic [7:0]   guard_reg;
        logic [7:0]   thresh_reg;
        logic [7:0]   input_reg;
        logic [7:0]   analog_reg;
        logic [7:0]   baud_reg;
        logic [7:0]   rdata;
        logic [6:0]   guard_left;
        logic [5:0]   unit_cnt;
        logic [12:0]  div_cnt;
        logic         baud_tick;
        rxcfg_frame_t fstate;
        logic [3:0]   bit_idx;
        logic         char_done;
        logic         collision;
        logic         dec_ok;
        logic         ph_ok;
        logic         rx_gated;
    } rxcfg_state_t;

endpackage

// [testbench/rxcfg_regs_tb.sv]
/*
 Self-checking bench of the receiver and serial speed configuration bank.
 Assumes the design package is compiled first and the consts header is
 on the include path; the bench drives every port itself.
*/
`timescale 1ns/1ps

module rxcfg_regs_tb
    import rxcfg_pkg::*;
;
    logic            ref_clk;
    logic            reset;
    rxcfg_bus_t      bus;
    logic [7:0]      rdata;
    logic            tx_end, half_bit_tick, rx_in, xtal_tick, char_start;
    logic [3:0]      signal_level, phase_level;
    logic [7:0]      main_strength, sec_strength;
    rxcfg_rx_ctrl_t  rx_ctrl;
    logic            rx_blank, rx_in_gated, decoder_level_ok;
    logic            phase_level_ok, collision, baud_tick;
    logic            char_active, char_done;
    logic [12:0]     baud_divisor;
    logic [3:0]      char_bit_index;
    int              err_count, num_checks;

    rxcfg_regs dut (.ref_clk(ref_clk), .reset(reset), .bus(bus),
        .rdata(rdata), .tx_end(tx_end), .half_bit_tick(half_bit_tick),
        .rx_in(rx_in), .signal_level(signal_level),
        .phase_level(phase_level), .main_strength(main_strength),
        .sec_strength(sec_strength), .xtal_tick(xtal_tick),
        .char_start(char_start), .rx_ctrl(rx_ctrl), .rx_blank(rx_blank),
        .rx_in_gated(rx_in_gated), .decoder_level_ok(decoder_level_ok),
        .phase_level_ok(phase_level_ok), .collision(collision),
        .baud_divisor(baud_divisor), .baud_tick(baud_tick),
        .char_active(char_active), .char_bit_index(char_bit_index),
        .char_done(char_done));

    // ==========================================================
    // Common tasks
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe edge
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd_reg(a, d);
        chk(d, e);
    endtask

    // Pulse tx_end, count blanked cycles; unit 1 gets a half-bit tick
    // every eighth cycle and the count returned is ticks seen
    task automatic guard_run(input logic unit, output int n);
        int i;
        n = 0;
        @(posedge ref_clk);
        tx_end <= 1'b1;
        @(posedge ref_clk);
        tx_end <= 1'b0;
        for (i = 0; i < 2000; i++)
        begin
            #1;
            if (rx_blank !== 1'b1)
                break;
            if (!unit)
                n++;
            @(posedge ref_clk);
            half_bit_tick <= unit && (i % 8 == 7);
            if (unit && (i % 8 == 7))
                n++;
            // The gated input trails the blank flag by one cycle
            #1 chk(rx_in_gated, 1'b0);
        end
        half_bit_tick <= 1'b0;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset_map();
        rd_chk(8'h36, 8'h00);
        rd_chk(8'h38, 8'h00);
        rd_chk(8'h3B, 8'h7A);
        chk(baud_divisor, 13'd236);
        wr_reg(8'h40, 8'h55);
        rd_chk(8'h40, 8'h00);
        wr_reg(8'h37, 8'h5A);
        rd_chk(8'h37, 8'h5A);
        wr_reg(8'h38, 8'hFF);
        rd_chk(8'h38, 8'hF3);
        wr_reg(8'h39, 8'h00);
        rd_chk(8'h39, 8'h00);
        wr_reg(8'h39, 8'h3F);
        rd_chk(8'h39, 8'h0F);
    endtask

    task automatic t_ctrl_codes();
        logic [1:0] k;
        for (int i = 0; i < 4; i++)
        begin
            k = i[1:0];
            wr_reg(8'h38, {k[0], k[1], k, 2'b00, k});
            wr_reg(8'h39, {4'h0, k, ~k});
            #1 chk(rx_ctrl, {k[0], k[1], k, k, k, ~k});
        end
    endtask

    task automatic t_guard();
        int n;
        rx_in <= 1'b1;
        wr_reg(8'h36, 8'h02);
        guard_run(1'b0, n);
        chk(n, 16'd116);
        @(posedge ref_clk);
        #1 chk(rx_in_gated, 1'b1);
        wr_reg(8'h36, 8'h00);
        guard_run(1'b0, n);
        chk(n, 16'd0);
        wr_reg(8'h36, 8'h83);
        guard_run(1'b1, n);
        chk(n, 16'd3);
    endtask

    task automatic t_levels();
        wr_reg(8'h37, 8'h5A);
        signal_level <= 4'h9;
        phase_level  <= 4'hC;
        repeat (2) @(posedge ref_clk);
        #1 chk({decoder_level_ok, phase_level_ok}, 2'b11);
        signal_level <= 4'h2;
        phase_level  <= 4'h3;
        repeat (2) @(posedge ref_clk);
        #1 chk({decoder_level_ok, phase_level_ok}, 2'b00);
    endtask

    task automatic t_collision();
        logic [7:0] thr;
        main_strength <= 8'h40;
        for (int c = 0; c < 4; c++)
        begin
            wr_reg(8'h38, {6'h00, c[1:0]});
            thr = (c == 3) ? 8'h40 : (8'h40 >> (3 - c));
            sec_strength <= thr;
            repeat (2) @(posedge ref_clk);
            #1 chk(collision, c != 3);
            if (c == 0)
                rd_chk(8'h3A, 8'h02);
            sec_strength <= thr - 8'h01;
            repeat (2) @(posedge ref_clk);
            #1 chk(collision, 1'b0);
        end
    endtask

    task automatic t_baud();
        // Settings stay at or below the fastest supported bit rate
        logic [7:0]  s [5] = '{8'h15, 8'hEB, 8'h3A, 8'h1C, 8'hFA};
        logic [12:0] e [5] = '{13'd22, 13'd2816, 13'd59, 13'd29, 13'd3776};
        int n;
        for (int i = 0; i < 5; i++)
        begin
            wr_reg(8'h3B, s[i]);
            #1 chk(baud_divisor, e[i]);
        end
        wr_reg(8'h3B, 8'h15);
        @(posedge ref_clk);
        char_start <= 1'b1;
        @(posedge ref_clk);
        char_start <= 1'b0;
        n = 0;
        for (int i = 0; i < 300; i++)
        begin
            @(posedge ref_clk);
            char_start <= (i == 5);
            #1;
            if (char_done === 1'b1)
                break;
            if (baud_tick === 1'b1)
            begin
                chk(char_bit_index, n[3:0]);
                n++;
            end
        end
        char_start <= 1'b0;
        chk(n, 16'd10);
        #1 chk(char_active, 1'b0);
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial
    begin
        err_count = 0;
        num_checks = 0;
        reset = 1'b1;
        bus = '0;
        {tx_end, half_bit_tick, rx_in, char_start} = 4'h0;
        xtal_tick = 1'b1;
        signal_level = 4'h0;
        phase_level = 4'h0;
        main_strength = 8'h00;
        sec_strength = 8'h00;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset_map();
        t_ctrl_codes();
        t_guard();
        t_levels();
        t_collision();
        t_baud();
        complete_run();
    end

    // Whole run is a few hundred cycles; allow a wide margin
    initial
    begin
        #400us;
        err_count++;
        complete_run();
    end
endmodule
